// ===== core/fsp_serial_port.sv
`timescale 1ns/100ps
module fsp_serial_port
   import fsp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        baud_tick,
   input  wire logic        rxd_in,
   output logic             rxd_out,
   output logic             rxd_oe,
   output logic             txd
);

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_BITS  = 4'b0100,
      RX_STOP  = 4'b1000
   } fsp_rx_state_t;

   typedef enum logic [1:0] {
      M0_IDLE  = 2'b01,
      M0_SHIFT = 2'b10
   } fsp_m0_state_t;

   // ==========================================================
   // Declarations
   // ==========================================================
   logic [1:0]    mode_r, mode_nxt;
   logic          mpe_r, mpe_nxt;
   logic          ren_r, ren_nxt;
   logic          tb8_r, tb8_nxt;
   logic          rb8_r, rb8_nxt;
   logic          ti_r, ti_nxt;
   logic          ri_r, ri_nxt;
   logic          fast_r, fast_nxt;
   logic [7:0]    buf_r, buf_nxt;
   logic [31:0]   prdata_r, prdata_nxt;
   logic          wr_en, rd_setup;
   logic          wr_ctrl, wr_buf, wr_rate;
   logic          mapped;
   logic          nine_bit;

   fsp_rx_state_t rx_state_r, rx_state_nxt;
   logic [3:0]    rx_ovs_r, rx_ovs_nxt;
   logic [3:0]    rx_cnt_r, rx_cnt_nxt;
   logic [8:0]    rx_sh_r, rx_sh_nxt;
   logic          rxd_prev_r;
   logic          a_done, a_accept;
   logic [7:0]    a_byte;
   logic          a_rb8;

   fsp_m0_state_t m0_state_r, m0_state_nxt;
   logic          m0_dir_r, m0_dir_nxt;
   logic [7:0]    m0_sh_r, m0_sh_nxt;
   logic [2:0]    m0_cnt_r, m0_cnt_nxt;
   logic          m0_clk_r, m0_clk_nxt;
   logic          m0_done;
   logic          m0_run;

   logic          tick16, m0_mid, m0_end;
   logic          tx_txd, tx_stop_begin;

   // ==========================================================
   // APB decode
   // ==========================================================
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign wr_ctrl  = wr_en && (paddr == FSP_CTRL_OFF);
   assign wr_buf   = wr_en && (paddr == FSP_BUF_OFF);
   assign wr_rate  = wr_en && (paddr == FSP_RATE_OFF);
   assign mapped   = (paddr == FSP_CTRL_OFF) || (paddr == FSP_BUF_OFF)
                  || (paddr == FSP_RATE_OFF);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign prdata   = prdata_r;
   assign nine_bit = mode_r[1];

   always_comb begin
      prdata_nxt = prdata_r;
      if (rd_setup) begin
         prdata_nxt = 32'h0000_0000;
         unique case (paddr)
            FSP_CTRL_OFF: prdata_nxt[7:0] = {mode_r, mpe_r, ren_r,
                                             tb8_r, rb8_r, ti_r, ri_r};
            FSP_BUF_OFF:  prdata_nxt[7:0] = buf_r;
            FSP_RATE_OFF: prdata_nxt[FSP_FAST_POS] = fast_r;
            default:      prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Control and receive buffer
   // ==========================================================
   always_comb begin
      mode_nxt = mode_r;
      mpe_nxt  = mpe_r;
      ren_nxt  = ren_r;
      tb8_nxt  = tb8_r;
      rb8_nxt  = rb8_r;
      ti_nxt   = ti_r;
      ri_nxt   = ri_r;
      fast_nxt = fast_r;
      buf_nxt  = buf_r;
      if (wr_ctrl) begin
         mode_nxt = {pwdata[FSP_MODE_HI_POS], pwdata[FSP_MODE_LO_POS]};
         mpe_nxt  = pwdata[FSP_MPE_POS];
         ren_nxt  = pwdata[FSP_REN_POS];
         tb8_nxt  = pwdata[FSP_TB8_POS];
         rb8_nxt  = pwdata[FSP_RB8_POS];
         ti_nxt   = pwdata[FSP_TI_POS];
         ri_nxt   = pwdata[FSP_RI_POS];
      end
      if (wr_rate) begin
         fast_nxt = pwdata[FSP_FAST_POS];
      end
      if ((m0_done && m0_dir_r) || tx_stop_begin) begin
         ti_nxt = 1'b1;
      end
      if (m0_done && !m0_dir_r) begin
         ri_nxt  = 1'b1;
         buf_nxt = m0_sh_r;
      end
      if (a_accept) begin
         ri_nxt  = 1'b1;
         buf_nxt = a_byte;
         rb8_nxt = a_rb8;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r   <= FSP_CTRL_RESET[FSP_MODE_HI_POS:FSP_MODE_LO_POS];
         mpe_r    <= FSP_CTRL_RESET[FSP_MPE_POS];
         ren_r    <= FSP_CTRL_RESET[FSP_REN_POS];
         tb8_r    <= FSP_CTRL_RESET[FSP_TB8_POS];
         rb8_r    <= FSP_CTRL_RESET[FSP_RB8_POS];
         ti_r     <= FSP_CTRL_RESET[FSP_TI_POS];
         ri_r     <= FSP_CTRL_RESET[FSP_RI_POS];
         fast_r   <= FSP_FAST_RESET;
         buf_r    <= FSP_BUF_RESET;
         prdata_r <= 32'h0000_0000;
      end else begin
         mode_r   <= mode_nxt;
         mpe_r    <= mpe_nxt;
         ren_r    <= ren_nxt;
         tb8_r    <= tb8_nxt;
         rb8_r    <= rb8_nxt;
         ti_r     <= ti_nxt;
         ri_r     <= ri_nxt;
         fast_r   <= fast_nxt;
         buf_r    <= buf_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ==========================================================
   // Asynchronous receiver, modes 1 to 3
   // ==========================================================
   assign a_done = (rx_state_r == RX_STOP) && tick16
                && (rx_ovs_r == FSP_OVS_LAST);
   assign a_byte = nine_bit ? rx_sh_r[7:0] : rx_sh_r[8:1];
   assign a_rb8  = nine_bit ? rx_sh_r[8] : rxd_in;
   // Unread byte keeps the new one out
   assign a_accept = a_done && !ri_r
                  && (!mpe_r || (nine_bit ? rx_sh_r[8] : rxd_in));

   always_comb begin
      rx_state_nxt = rx_state_r;
      rx_ovs_nxt   = rx_ovs_r;
      rx_cnt_nxt   = rx_cnt_r;
      rx_sh_nxt    = rx_sh_r;
      unique case (rx_state_r)
         RX_IDLE: begin
            if (mode_r != FSP_MODE_SHIFT && ren_r && rxd_prev_r
                && !rxd_in) begin
               rx_state_nxt = RX_START;
               rx_ovs_nxt   = 4'h0;
            end
         end
         RX_START: begin
            if (tick16) begin
               rx_ovs_nxt = 4'(rx_ovs_r + 4'h1);
               if (rx_ovs_r == FSP_OVS_MID) begin
                  rx_ovs_nxt   = 4'h0;
                  rx_cnt_nxt   = 4'h0;
                  rx_state_nxt = rxd_in ? RX_IDLE : RX_BITS;
               end
            end
         end
         RX_BITS: begin
            if (tick16) begin
               rx_ovs_nxt = 4'(rx_ovs_r + 4'h1);
               if (rx_ovs_r == FSP_OVS_LAST) begin
                  rx_sh_nxt  = {rxd_in, rx_sh_r[8:1]};
                  rx_cnt_nxt = 4'(rx_cnt_r + 4'h1);
                  if (rx_cnt_r == (nine_bit ? 4'h8 : 4'h7)) begin
                     rx_state_nxt = RX_STOP;
                  end
               end
            end
         end
         RX_STOP: begin
            if (tick16) begin
               rx_ovs_nxt = 4'(rx_ovs_r + 4'h1);
               if (a_done) begin
                  rx_state_nxt = RX_IDLE;
               end
            end
         end
      endcase
      if (mode_r == FSP_MODE_SHIFT) begin
         rx_state_nxt = RX_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_r <= RX_IDLE;
         rx_ovs_r   <= 4'h0;
         rx_cnt_r   <= 4'h0;
         rx_sh_r    <= 9'h000;
         rxd_prev_r <= 1'b1;
      end else begin
         rx_state_r <= rx_state_nxt;
         rx_ovs_r   <= rx_ovs_nxt;
         rx_cnt_r   <= rx_cnt_nxt;
         rx_sh_r    <= rx_sh_nxt;
         rxd_prev_r <= rxd_in;
      end
   end

   // ==========================================================
   // Mode 0 shift engine, both directions on rxd
   // ==========================================================
   assign m0_run  = (m0_state_r == M0_SHIFT);
   assign m0_done = m0_run && m0_end && (m0_cnt_r == FSP_M0_BITS);

   always_comb begin
      m0_state_nxt = m0_state_r;
      m0_dir_nxt   = m0_dir_r;
      m0_sh_nxt    = m0_sh_r;
      m0_cnt_nxt   = m0_cnt_r;
      m0_clk_nxt   = m0_clk_r;
      unique case (m0_state_r)
         M0_IDLE: begin
            if (mode_r == FSP_MODE_SHIFT) begin
               if (wr_buf) begin
                  m0_state_nxt = M0_SHIFT;
                  m0_dir_nxt   = 1'b1;
                  m0_sh_nxt    = pwdata[7:0];
                  m0_cnt_nxt   = 3'h0;
                  m0_clk_nxt   = 1'b0;
               end else if (ren_r && !ri_r) begin
                  m0_state_nxt = M0_SHIFT;
                  m0_dir_nxt   = 1'b0;
                  m0_cnt_nxt   = 3'h0;
                  m0_clk_nxt   = 1'b0;
               end
            end
         end
         M0_SHIFT: begin
            if (m0_mid) begin
               m0_clk_nxt = 1'b1;
               if (!m0_dir_r) begin
                  m0_sh_nxt = {rxd_in, m0_sh_r[7:1]};
               end
            end
            if (m0_end) begin
               m0_cnt_nxt = 3'(m0_cnt_r + 3'h1);
               if (m0_dir_r) begin
                  m0_sh_nxt = {1'b1, m0_sh_r[7:1]};
               end
               if (m0_done) begin
                  m0_state_nxt = M0_IDLE;
               end else begin
                  m0_clk_nxt = 1'b0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m0_state_r <= M0_IDLE;
         m0_dir_r   <= 1'b0;
         m0_sh_r    <= 8'hFF;
         m0_cnt_r   <= 3'h0;
         m0_clk_r   <= 1'b1;
      end else begin
         m0_state_r <= m0_state_nxt;
         m0_dir_r   <= m0_dir_nxt;
         m0_sh_r    <= m0_sh_nxt;
         m0_cnt_r   <= m0_cnt_nxt;
         m0_clk_r   <= m0_clk_nxt;
      end
   end

   // ==========================================================
   // Rate generator and asynchronous transmitter
   // ==========================================================
   fsp_baud u_baud (
      .pclk      (pclk),
      .presetn   (presetn),
      .mode      (mode_r),
      .fast_rate (fast_r),
      .baud_tick (baud_tick),
      .m0_run    (m0_run),
      .tick16    (tick16),
      .m0_mid    (m0_mid),
      .m0_end    (m0_end)
   );

   fsp_tx u_tx (
      .pclk       (pclk),
      .presetn    (presetn),
      .start      (wr_buf && (mode_r != FSP_MODE_SHIFT)),
      .data       (pwdata[7:0]),
      .ninth      (tb8_r),
      .nine_bit   (nine_bit),
      .tick16     (tick16),
      .txd        (tx_txd),
      .busy       (),
      .stop_begin (tx_stop_begin)
   );

   // Shift clock on txd in mode 0
   assign txd     = (mode_r == FSP_MODE_SHIFT) ? m0_clk_r : tx_txd;
   assign rxd_out = m0_sh_r[0];
   assign rxd_oe  = m0_run && m0_dir_r;

endmodule

// ===== core/fsp_pkg.sv
package fsp_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [7:0] FSP_CTRL_OFF  = 8'h98;
   localparam logic [7:0] FSP_BUF_OFF   = 8'h9C;
   localparam logic [7:0] FSP_RATE_OFF  = 8'hA0;

   // ==========================================================
   // Control and rate register fields
   // ==========================================================
   localparam int FSP_MODE_HI_POS = 7;
   localparam int FSP_MODE_LO_POS = 6;
   localparam int FSP_MPE_POS     = 5;
   localparam int FSP_REN_POS     = 4;
   localparam int FSP_TB8_POS     = 3;
   localparam int FSP_RB8_POS     = 2;
   localparam int FSP_TI_POS      = 1;
   localparam int FSP_RI_POS      = 0;
   localparam int FSP_FAST_POS    = 0;

   localparam logic [7:0] FSP_CTRL_RESET = 8'h00;
   localparam logic [7:0] FSP_BUF_RESET  = 8'h00;
   localparam logic       FSP_FAST_RESET = 1'b0;

   // ==========================================================
   // Timing counts
   // ==========================================================
   localparam logic [3:0] FSP_M0_MID    = 4'h5;
   localparam logic [3:0] FSP_M0_LAST   = 4'hB;
   localparam logic [3:0] FSP_OVS_MID   = 4'h7;
   localparam logic [3:0] FSP_OVS_LAST  = 4'hF;
   localparam logic [1:0] FSP_M2_SLOW   = 2'h3;
   localparam logic [1:0] FSP_M2_FAST   = 2'h1;
   localparam logic [3:0] FSP_FRAME8    = 4'hA;
   localparam logic [3:0] FSP_FRAME9    = 4'hB;
   localparam logic [2:0] FSP_M0_BITS   = 3'h7;

   typedef enum logic [1:0] {
      FSP_MODE_SHIFT = 2'b00,
      FSP_MODE_UART8 = 2'b01,
      FSP_MODE_UART9F = 2'b10,
      FSP_MODE_UART9V = 2'b11
   } fsp_mode_t;

endpackage

// ===== core/fsp_baud.sv
`timescale 1ns/100ps
module fsp_baud
   import fsp_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [1:0] mode,
   input  wire logic       fast_rate,
   input  wire logic       baud_tick,
   input  wire logic       m0_run,
   output logic            tick16,
   output logic            m0_mid,
   output logic            m0_end
);

   logic [3:0] m0_cnt_r;
   logic [3:0] m0_cnt_nxt;
   logic [1:0] div_cnt_r;
   logic [1:0] div_cnt_nxt;
   logic [1:0] div_last;

   // ==========================================================
   // Dividers
   // ==========================================================
   always_comb begin
      div_last = fast_rate ? FSP_M2_FAST : FSP_M2_SLOW;
      if (div_cnt_r >= div_last) begin
         div_cnt_nxt = 2'h0;
      end else begin
         div_cnt_nxt = 2'(div_cnt_r + 2'h1);
      end
      if (!m0_run || m0_cnt_r == FSP_M0_LAST) begin
         m0_cnt_nxt = 4'h0;
      end else begin
         m0_cnt_nxt = 4'(m0_cnt_r + 4'h1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m0_cnt_r  <= 4'h0;
         div_cnt_r <= 2'h0;
      end else begin
         m0_cnt_r  <= m0_cnt_nxt;
         div_cnt_r <= div_cnt_nxt;
      end
   end

   assign tick16 = (mode == FSP_MODE_UART9F) ? (div_cnt_r >= div_last)
                 : ((mode != FSP_MODE_SHIFT) && baud_tick);
   assign m0_mid = m0_run && (m0_cnt_r == FSP_M0_MID);
   assign m0_end = m0_run && (m0_cnt_r == FSP_M0_LAST);

endmodule

// ===== core/fsp_tx.sv
`timescale 1ns/100ps
module fsp_tx
   import fsp_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic [7:0] data,
   input  wire logic       ninth,
   input  wire logic       nine_bit,
   input  wire logic       tick16,
   output logic            txd,
   output logic            busy,
   output logic            stop_begin
);

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } fsp_tx_state_t;

   fsp_tx_state_t state_r;
   fsp_tx_state_t state_nxt;
   logic [10:0]   sh_r;
   logic [10:0]   sh_nxt;
   logic [3:0]    left_r;
   logic [3:0]    left_nxt;
   logic [3:0]    ovs_r;
   logic [3:0]    ovs_nxt;
   logic          bit_end;

   assign bit_end = (state_r == TX_SEND) && tick16 && (ovs_r == FSP_OVS_LAST);

   // ==========================================================
   // Frame shifter
   // ==========================================================
   always_comb begin
      state_nxt = state_r;
      sh_nxt    = sh_r;
      left_nxt  = left_r;
      ovs_nxt   = ovs_r;
      if (start) begin
         state_nxt = TX_SEND;
         sh_nxt    = {1'b1, nine_bit ? ninth : 1'b1, data, 1'b0};
         left_nxt  = nine_bit ? FSP_FRAME9 : FSP_FRAME8;
         ovs_nxt   = 4'h0;
      end else if (state_r == TX_SEND && tick16) begin
         ovs_nxt = 4'(ovs_r + 4'h1);
         if (bit_end) begin
            sh_nxt   = {1'b1, sh_r[10:1]};
            left_nxt = 4'(left_r - 4'h1);
            if (left_r == 4'h1) begin
               state_nxt = TX_IDLE;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= TX_IDLE;
         sh_r    <= 11'h7FF;
         left_r  <= 4'h0;
         ovs_r   <= 4'h0;
      end else begin
         state_r <= state_nxt;
         sh_r    <= sh_nxt;
         left_r  <= left_nxt;
         ovs_r   <= ovs_nxt;
      end
   end

   assign txd  = sh_r[0];
   assign busy = (state_r == TX_SEND);
   assign stop_begin = bit_end && (left_r == 4'h2);

endmodule

// ===== verification/fsp_serial_port_sva.sv
`timescale 1ns/100ps
module fsp_serial_port_sva
   import fsp_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        baud_tick,
   input wire logic        rxd_in,
   input wire logic        rxd_out,
   input wire logic        rxd_oe,
   input wire logic        txd
);
   // ========
   // Shadow of control writes
   // ========
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   logic       acc;
   logic       map;
   assign acc = psel && penable;
   assign map = paddr == FSP_CTRL_OFF || paddr == FSP_BUF_OFF
             || paddr == FSP_RATE_OFF;
   always_comb begin
      sh_nxt = sh_r;
      if (acc && pwrite && paddr == FSP_CTRL_OFF) begin
         sh_nxt = pwdata[7:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_r <= FSP_CTRL_RESET;
      end else begin
         sh_r <= sh_nxt;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ========
   // Checks
   // ========
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_unmap: assert property (acc && !map |-> pslverr)
      else $error("no error on unmapped access");
   a_err_map: assert property (acc && map |-> !pslverr)
      else $error("error on mapped access");
   a_unmap_zero: assert property (
      acc && !map && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (
      acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_ctrl_back: assert property (
      acc && !pwrite && paddr == FSP_CTRL_OFF
      |-> prdata[7:3] == sh_r[7:3])
      else $error("control fields lost");
   a_tx_start: assert property (
      acc && pwrite && paddr == FSP_BUF_OFF && sh_r[7:6] != 2'b00
      |=> !txd)
      else $error("no start bit after buffer write");
   a_oe_mode: assert property (rxd_oe |-> sh_r[7:6] == 2'b00)
      else $error("rxd driven outside shift mode");
   a_m0_clock: assert property (
      sh_r[7:6] == 2'b00 && $fell(txd) |-> !txd[*6] ##1 txd[*6])
      else $error("shift clock shape wrong");
endmodule

bind fsp_serial_port fsp_serial_port_sva u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick),
   .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd)
);

// ===== verification/fsp_line_model.sv
`timescale 1ns/100ps
module fsp_line_model (
   input  wire logic pclk,
   input  wire logic baud_tick,
   input  wire logic txd,
   input  wire logic rxd_out,
   input  wire logic rxd_oe,
   output logic      rxd_in
);
   logic line_r = 1'b1;
   int   lost = 0;
   assign rxd_in = rxd_oe ? rxd_out : line_r;

   task automatic waitb(input int per, input int div);
      if (per == 0) begin
         repeat (16 / div) @(posedge pclk iff baud_tick);
      end else begin
         repeat (per / div) @(posedge pclk);
      end
   endtask

   task automatic lvl(input logic v);
      for (int k = 0; k < 5000 && lost == 0 && txd !== v; k++) begin
         @(posedge pclk);
      end
      // Level never came: flag it for the bench
      if (txd !== v) begin
         lost++;
      end
   endtask

   task automatic get(input int n, input int per,
                      output logic [31:0] f);
      f = 32'h0;
      for (int i = 0; i < n; i++) begin
         if (n == 8) begin
            lvl(1'b0);
            lvl(1'b1);
            f[i] = rxd_out;
         end else begin
            if (i == 0) begin
               lvl(1'b0);
               waitb(per, 2);
            end
            waitb(per, 1);
            f[i] = txd;
         end
      end
      if (n == 8) begin
         repeat (6) @(posedge pclk);
      end
   endtask

   // Frame onto the line, mode 0 paced by txd
   task automatic send(input logic [10:0] fr, input int n);
      for (int i = 0; i < n; i++) begin
         if (n == 8) begin
            lvl(1'b0);
            line_r <= fr[i];
            lvl(1'b1);
         end else begin
            line_r <= fr[i];
            waitb(0, 1);
         end
      end
      if (n == 8) begin
         repeat (6) @(posedge pclk);
      end
      line_r <= 1'b1;
   endtask
endmodule

// ===== verification/fsp_serial_port_tb.sv
`timescale 1ns/100ps
module fsp_serial_port_tb
   import fsp_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        baud_tick = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rxd_in;
   logic        rxd_out;
   logic        rxd_oe;
   logic        txd;
   logic        last_err;
   int          err_count = 0;
   int          num_checks = 0;

   always #2 pclk = ~pclk;
   always @(posedge pclk) baud_tick <= ~baud_tick;

   fsp_serial_port DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick),
      .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd)
   );
   fsp_line_model u_line (
      .pclk(pclk), .baud_tick(baud_tick), .txd(txd),
      .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in)
   );

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         err_count++;
         stop_test();
      end
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask

   task automatic guard;
      if (u_line.lost != 0) begin
         err_count++;
         stop_test();
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      apb(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask

   task automatic tx_case(input logic [7:0] c, input logic [7:0] d,
         input int n, input int per, input logic [31:0] ef,
         input logic [7:0] ec);
      logic [31:0] f;
      wr(FSP_CTRL_OFF, {24'h0, c});
      wr(FSP_BUF_OFF, {24'h0, d});
      u_line.get(n, per, f);
      guard();
      chk(f, ef);
      rdc(FSP_CTRL_OFF, {24'h0, ec});
   endtask

   task automatic rx_case(input logic [7:0] c, input logic [10:0] fr,
         input int n, input logic [7:0] ec, input logic [7:0] eb);
      if (c != 8'h00) begin
         wr(FSP_CTRL_OFF, {24'h0, c});
      end
      u_line.send(fr, n);
      guard();
      rdc(FSP_CTRL_OFF, {24'h0, ec});
      rdc(FSP_BUF_OFF, {24'h0, eb});
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc(FSP_CTRL_OFF, 32'h0);
      rdc(FSP_BUF_OFF, 32'h0);
      rdc(8'h80, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      wr(FSP_CTRL_OFF, 32'hF8);
      rdc(FSP_CTRL_OFF, 32'hF8);
      wr(FSP_CTRL_OFF, 32'h00);
      $display("register tests done");
      tx_case(8'h00, 8'h96, 8, 0, 32'h96, 8'h02);
      tx_case(8'h40, 8'hA5, 9, 0, 32'h1A5, 8'h42);
      tx_case(8'hC8, 8'h3C, 10, 0, 32'h33C, 8'hCA);
      tx_case(8'h80, 8'hC3, 10, 64, 32'h2C3, 8'h82);
      wr(FSP_RATE_OFF, 32'h1);
      rdc(FSP_RATE_OFF, 32'h1);
      tx_case(8'h88, 8'h81, 10, 32, 32'h381, 8'h8A);
      $display("tx tests done");
      rx_case(8'h50, {1'b1, 8'h5A, 1'b0}, 10, 8'h55, 8'h5A);
      rx_case(8'h00, {1'b1, 8'h33, 1'b0}, 10, 8'h55, 8'h5A);
      rx_case(8'h40, {1'b1, 8'h77, 1'b0}, 10, 8'h40, 8'h5A);
      rx_case(8'h70, {1'b0, 8'h44, 1'b0}, 10, 8'h70, 8'h5A);
      rx_case(8'hF0, {2'b10, 8'h11, 1'b0}, 11, 8'hF0, 8'h5A);
      rx_case(8'h00, {2'b11, 8'h22, 1'b0}, 11, 8'hF5, 8'h22);
      rx_case(8'hD0, {2'b10, 8'h66, 1'b0}, 11, 8'hD1, 8'h66);
      rx_case(8'h10, {3'b111, 8'hC6}, 8, 8'h11, 8'hC6);
      $display("rx tests done");
      stop_test();
   end
endmodule
